//--- hdl/aof_consts.vh
// Constants for the converter oversampling and averaging filter
//
// Notes on behaviour
// - Filter runs while enable bit is set; clearing it stops filter, clears ready.
// - Mode field bits 14:13: 11 averaging, 00 oversampling, others reserved.
// - Oversampling at 128 conversions gives a 16-bit result in 12.4 format.
// - Oversampling ratio code 110: 32 conversions, 15-bit result in 12.3 format.
// - Oversampling ratio code 011: 256 conversions, 16-bit result in 12.4 format.
// - Oversampling ratio code 010: 64 conversions, 15-bit result.
// - Oversampling ratio code 000: 4 conversions, 13-bit result in 12.1 format.
// - Oversampling ratio code 001: 16 conversions, 14-bit result.
`ifndef AOF_CONSTS_VH
`define AOF_CONSTS_VH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define AOF_OFS_CONTROL    8'h00
`define AOF_OFS_RESULT     8'h04
`define AOF_OFS_STATUS     8'h08
`define AOF_OFS_INT_STATUS 8'h0C
`define AOF_OFS_INT_CLEAR  8'h10
`define AOF_OFS_INT_ENABLE 8'h14

// ----------------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------------
`define AOF_CTL_ENABLE_BIT 15
`define AOF_CTL_MODE_HI    14
`define AOF_CTL_MODE_LO    13
`define AOF_CTL_RATIO_HI   12
`define AOF_CTL_RATIO_LO   10
`define AOF_CTL_IE_BIT     9
`define AOF_CTL_CHAN_HI    4
`define AOF_CTL_CHAN_LO    0
`define AOF_CTL_WMASK      16'hFE1F
`define AOF_CTL_RESET      16'h0000

// ----------------------------------------------------------------------------
// Mode codes
// ----------------------------------------------------------------------------
`define AOF_MODE_OVERSAMPLE 2'h0
`define AOF_MODE_AVERAGE    2'h3

// ----------------------------------------------------------------------------
// Status and interrupt bits
// ----------------------------------------------------------------------------
`define AOF_ST_READY_BIT   0
`define AOF_ST_BUSY_BIT    1
`define AOF_INT_DONE_BIT   0
`define AOF_INT_OVERRUN_BIT 1
`define AOF_INT_WIDTH      2

`endif

//--- hdl/aof_filter.v
// Converter oversampling and averaging post-processing filter with register port
//
// The implementer's own choices: the register addresses and strobed register access.
`timescale 1ns/10ps
`include "aof_consts.vh"

module aof_filter
#(
    parameter DATA_WIDTH = 12,
    parameter CHAN_WIDTH = 5,
    parameter ADDR_WIDTH = 8,
    parameter SUM_WIDTH  = 20
)
(
    // Clock and reset
    input  wire                  clk,
    input  wire                  reset,
    // Register port
    input  wire [ADDR_WIDTH-1:0] regAddr,
    input  wire [15:0]           regWrData,
    input  wire                  regWrite,
    input  wire                  regRead,
    output reg  [15:0]           regRdData,
    // Conversion results from the converter
    input  wire                  sampleValid,
    input  wire [CHAN_WIDTH-1:0] sampleChannel,
    input  wire [DATA_WIDTH-1:0] sampleData,
    // Status outputs
    output wire                  resultReady,
    output wire                  irq
);

    // ------------------------------------------------------------------------
    // Ratio decoding
    // ------------------------------------------------------------------------
    // Base-two logarithm of the conversion count for a ratio code
    function [3:0] ratioLog2;
        input [2:0] code;
        begin
            case (code)
                3'h0:    ratioLog2 = 4'h2;
                3'h1:    ratioLog2 = 4'h4;
                3'h2:    ratioLog2 = 4'h6;
                3'h3:    ratioLog2 = 4'h8;
                3'h4:    ratioLog2 = 4'h1;   // 2x
                3'h5:    ratioLog2 = 4'h3;   // 8x
                3'h6:    ratioLog2 = 4'h5;
                3'h7:    ratioLog2 = 4'h7;
                default: ratioLog2 = 4'h2;
            endcase
        end
    endfunction

    // True when a strobe addresses the register at the given offset
    function regHit;
        input [ADDR_WIDTH-1:0] addr;
        input [ADDR_WIDTH-1:0] offset;
        begin
            regHit = (addr == offset);
        end
    endfunction

    // ------------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------------
    reg  [15:0]                 control;
    reg  [15:0]                 result;
    reg                         ready;
    reg  [`AOF_INT_WIDTH-1:0]   intStatus;
    reg  [`AOF_INT_WIDTH-1:0]   intEnable;
    reg  [SUM_WIDTH-1:0]        accum;
    reg  [8:0]                  sampleCount;

    wire                        filterEnable;
    wire [1:0]                  filterMode;
    wire [2:0]                  filter_ratio_field;
    wire                        filter_interrupt_enable;
    wire [CHAN_WIDTH-1:0]       filter_channel_select;
    wire                        modeValid;
    wire                        averaging;
    wire [3:0]                  log2Count;
    wire [3:0]                  shiftAmount;
    wire [8:0]                  targetCount;
    wire                        takeSample;
    wire                        lastSample;
    wire [SUM_WIDTH-1:0]        sumNext;
    wire [SUM_WIDTH-1:0]        shiftedSum;
    wire                        ctlWrite;
    wire                        resultRead;
    wire                        clearWrite;
    wire                        doneEvent;
    wire                        overrunEvent;
    wire [`AOF_INT_WIDTH-1:0]   intEvents;
    wire                        intEnableWrite;
    wire                        disableWrite;
    wire [`AOF_INT_WIDTH-1:0]   next_intStatus;
    wire [15:0]                 statusWord;
    wire [15:0]                 intStatusWord;
    wire [15:0]                 intEnableWord;

    reg  [SUM_WIDTH-1:0]        next_accum;
    reg  [8:0]                  next_sampleCount;
    reg  [15:0]                 next_result;
    reg                         next_ready;
    reg  [15:0]                 next_control;
    reg  [`AOF_INT_WIDTH-1:0]   next_intEnable;
    reg  [15:0]                 next_regRdData;

    assign filterEnable            = control[`AOF_CTL_ENABLE_BIT];
    assign filterMode              = control[`AOF_CTL_MODE_HI:`AOF_CTL_MODE_LO];
    assign filter_ratio_field      = control[`AOF_CTL_RATIO_HI:`AOF_CTL_RATIO_LO];
    assign filter_interrupt_enable = control[`AOF_CTL_IE_BIT];
    assign filter_channel_select   = control[`AOF_CTL_CHAN_HI:`AOF_CTL_CHAN_LO];

    // ------------------------------------------------------------------------
    // Mode and ratio
    // ------------------------------------------------------------------------
    // Reserved mode codes leave the filter idle rather than guessing a meaning
    assign averaging = (filterMode == `AOF_MODE_AVERAGE);
    assign modeValid = averaging || (filterMode == `AOF_MODE_OVERSAMPLE);
    assign log2Count = ratioLog2(filter_ratio_field);
    assign targetCount = 9'h001 << log2Count;
    // Oversampling keeps half the growth: 12 + ceil(n/2) result bits
    assign shiftAmount = averaging ? log2Count
                                   : {1'b0, log2Count[3:1]};

    // ------------------------------------------------------------------------
    // Accumulator
    // ------------------------------------------------------------------------
    assign takeSample = filterEnable && modeValid && sampleValid
                        && (sampleChannel == filter_channel_select);
    assign lastSample = takeSample && ((sampleCount + 9'h001) == targetCount);
    // Sum width must hold 256 full-scale samples or the top ratio wraps
    assign sumNext    = accum + {{(SUM_WIDTH-DATA_WIDTH){1'b0}}, sampleData};
    assign shiftedSum = sumNext >> shiftAmount;

    // Control write restarts the run so a half-filled sum never mixes settings
    always @*
    begin
        next_accum       = accum;
        next_sampleCount = sampleCount;
        if (ctlWrite || !filterEnable)
        begin
            next_accum       = {SUM_WIDTH{1'b0}};
            next_sampleCount = 9'h000;
        end
        else if (lastSample)
        begin
            next_accum       = {SUM_WIDTH{1'b0}};
            next_sampleCount = 9'h000;
        end
        else if (takeSample)
        begin
            next_accum       = sumNext;
            next_sampleCount = sampleCount + 9'h001;
        end
    end

    always @(posedge clk)
    begin
        if (reset)
        begin
            accum       <= {SUM_WIDTH{1'b0}};
            sampleCount <= 9'h000;
        end
        else
        begin
            accum       <= next_accum;
            sampleCount <= next_sampleCount;
        end
    end

    always @*
    begin
        next_result = result;
        if (lastSample)
        begin
            next_result = shiftedSum[15:0];
        end
    end

    always @(posedge clk)
    begin
        if (reset)
        begin
            result <= 16'h0000;
        end
        else
        begin
            result <= next_result;
        end
    end

    // ------------------------------------------------------------------------
    // Ready flag
    // ------------------------------------------------------------------------
    // Completion wins over a read in the same cycle; disable clears outright,
    // already on the write that drops the enable bit
    always @*
    begin
        next_ready = ready;
        if (!filterEnable || disableWrite)
        begin
            next_ready = 1'b0;
        end
        else if (lastSample)
        begin
            next_ready = 1'b1;
        end
        else if (resultRead)
        begin
            next_ready = 1'b0;
        end
    end

    always @(posedge clk)
    begin
        if (reset)
        begin
            ready <= 1'b0;
        end
        else
        begin
            ready <= next_ready;
        end
    end

    assign resultReady = ready;

    // ------------------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------------------
    assign ctlWrite       = regWrite && regHit(regAddr, `AOF_OFS_CONTROL);
    assign disableWrite   = ctlWrite && !regWrData[`AOF_CTL_ENABLE_BIT];
    assign clearWrite     = regWrite && regHit(regAddr, `AOF_OFS_INT_CLEAR);
    assign intEnableWrite = regWrite && regHit(regAddr, `AOF_OFS_INT_ENABLE);
    assign resultRead     = regRead && regHit(regAddr, `AOF_OFS_RESULT);

    assign statusWord    = {14'h0000, (sampleCount != 9'h000), ready};
    assign intStatusWord = {14'h0000, intStatus};
    assign intEnableWord = {14'h0000, intEnable};

    // Unimplemented control bits are dropped here so they always read zero
    always @*
    begin
        next_control = control;
        if (ctlWrite)
        begin
            next_control = regWrData & `AOF_CTL_WMASK;
        end
    end

    always @(posedge clk)
    begin
        if (reset)
        begin
            control <= `AOF_CTL_RESET;
        end
        else
        begin
            control <= next_control;
        end
    end

    always @*
    begin
        next_intEnable = intEnable;
        if (intEnableWrite)
        begin
            next_intEnable = regWrData[`AOF_INT_WIDTH-1:0];
        end
    end

    always @(posedge clk)
    begin
        if (reset)
        begin
            intEnable <= {`AOF_INT_WIDTH{1'b0}};
        end
        else
        begin
            intEnable <= next_intEnable;
        end
    end

    // Read data stands one cycle only so a stale word never lingers on the port
    always @*
    begin
        next_regRdData = 16'h0000;
        if (regRead)
        begin
            case (regAddr)
                `AOF_OFS_CONTROL:    next_regRdData = control;
                `AOF_OFS_RESULT:     next_regRdData = result;
                `AOF_OFS_STATUS:     next_regRdData = statusWord;
                `AOF_OFS_INT_STATUS: next_regRdData = intStatusWord;
                `AOF_OFS_INT_ENABLE: next_regRdData = intEnableWord;
                default:             next_regRdData = 16'h0000;
            endcase
        end
    end

    always @(posedge clk)
    begin
        if (reset)
        begin
            regRdData <= 16'h0000;
        end
        else
        begin
            regRdData <= next_regRdData;
        end
    end

    // ------------------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------------------
    // Done posts only with the control interrupt bit; overrun always posts
    assign doneEvent    = lastSample && filter_interrupt_enable;
    assign overrunEvent = lastSample && ready && !resultRead;
    assign intEvents    = {overrunEvent, doneEvent};

    // Set beats a clear landing in the same cycle
    genvar i;
    generate
        for (i = 0; i < `AOF_INT_WIDTH; i = i + 1)
        begin : gStatus
            assign next_intStatus[i] = intEvents[i]
                                       || (intStatus[i] && !(clearWrite && regWrData[i]));
        end
    endgenerate

    always @(posedge clk)
    begin
        if (reset)
        begin
            intStatus <= {`AOF_INT_WIDTH{1'b0}};
        end
        else
        begin
            intStatus <= next_intStatus;
        end
    end

    assign irq = |(intStatus & intEnable);

endmodule // aof_filter

//--- tb/aof_conv_model.sv
// Converter model issuing conversion results
`timescale 1ns/10ps

module aof_conv_model
(
    // Clock
    input  logic        clk,
    // Conversion results
    output logic        sampleValid,
    output logic [4:0]  sampleChannel,
    output logic [11:0] sampleData
);
    initial
    begin
        sampleValid = 1'b0;
        sampleChannel = 5'h1F;
        sampleData = 12'h000;
    end

    // Idle data is inverted so a stale value never passes for a fresh one
    task automatic send(input logic [4:0] ch, input logic [11:0] d, input int gap);
        @(posedge clk);
        sampleValid <= 1'b1;
        sampleChannel <= ch;
        sampleData <= d;
        @(posedge clk);
        sampleValid <= 1'b0;
        sampleData <= ~d;
        repeat (gap) @(posedge clk);
        #1;
    endtask
endmodule // aof_conv_model

//--- tb/aof_filter_chk.sv
// Port checks for the oversampling filter
`timescale 1ns/10ps

module aof_filter_chk
(
    // Clock and reset
    input logic        clk,
    input logic        reset,
    // Ports watched
    input logic [7:0]  regAddr,
    input logic [15:0] regWrData,
    input logic        regWrite,
    input logic        regRead,
    input logic [15:0] regRdData,
    input logic        sampleValid,
    input logic        resultReady,
    input logic        irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    property p_rd0; !$past(regRead) |-> regRdData == 16'h0000; endproperty
    a_rd0: assert property (p_rd0) else $error("read data outside read slot");
    property p_unm; regRead && regAddr == 8'h20 |=> regRdData == 16'h0000; endproperty
    a_unm: assert property (p_unm) else $error("unmapped read not zero");
    property p_ctl;
        regWrite && regAddr == 8'h00 ##1 !regWrite ##1 regRead && regAddr == 8'h00
        |=> regRdData == ($past(regWrData, 3) & 16'hFE1F);
    endproperty
    a_ctl: assert property (p_ctl) else $error("control readback wrong");
    property p_en; regWrite && regAddr == 8'h00 && !regWrData[15] |=> !resultReady; endproperty
    a_en: assert property (p_en) else $error("ready kept after disable");
    property p_rdy; $rose(resultReady) |-> $past(sampleValid); endproperty
    a_rdy: assert property (p_rdy) else $error("ready without a sample");
    property p_rclr; regRead && regAddr == 8'h04 && !sampleValid |=> !resultReady; endproperty
    a_rclr: assert property (p_rclr) else $error("ready kept after read");
    property p_mask; regWrite && regAddr == 8'h14 && regWrData[1:0] == 2'h0 |=> !irq; endproperty
    a_mask: assert property (p_mask) else $error("masked interrupt high");
    property p_iclr;
        regWrite && regAddr == 8'h10 && regWrData[1:0] == 2'h3 && !sampleValid |=> !irq;
    endproperty
    a_iclr: assert property (p_iclr) else $error("cleared interrupt high");
endmodule // aof_filter_chk

bind aof_filter aof_filter_chk aof_filter_chk_inst (.clk, .reset, .regAddr, .regWrData,
    .regWrite, .regRead, .regRdData, .sampleValid, .resultReady, .irq);

//--- tb/aof_filter_test.sv
// Self-checking bench for the oversampling filter
`timescale 1ns/10ps

module aof_filter_test;
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic [7:0]  regAddr = 8'h00;
    logic [15:0] regWrData = 16'h0000;
    logic        regWrite = 1'b0;
    logic        regRead = 1'b0;
    logic [15:0] regRdData;
    logic        sampleValid;
    logic [4:0]  sampleChannel;
    logic [11:0] sampleData;
    logic        resultReady;
    logic        irq;
    logic [15:0] rv;
    int          n_mismatch = 0;
    int          n_compared = 0;
    int          cycles = 0;

    always #25 clk = ~clk;

    aof_filter aof_filter_inst (.clk, .reset, .regAddr, .regWrData, .regWrite, .regRead,
        .regRdData, .sampleValid, .sampleChannel, .sampleData, .resultReady, .irq);
    aof_conv_model aof_conv_model_inst (.clk, .sampleValid, .sampleChannel, .sampleData);

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        regWrite <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge clk);
        regWrite <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRead <= 1'b0;
        #1;
        rv = regRdData;
    endtask

    task automatic feed(input logic [11:0] v, input int n);
        repeat (n) aof_conv_model_inst.send(5'h03, v, 0);
    endtask

    task automatic t_reset();
        rd(8'h00);
        chk("control", 16'h0000, rv);
        rd(8'h20);
        chk("unmapped", 16'h0000, rv);
        $display("reset test done");
    endtask

    // Constant input v gives v shifted by the fraction width of each format
    task automatic t_ratio();
        logic [2:0] code [6] = '{3'h0, 3'h1, 3'h2, 3'h6, 3'h7, 3'h3};
        int         n [6] = '{4, 16, 64, 32, 128, 256};
        int         f [6] = '{1, 2, 3, 3, 4, 4};
        logic [11:0] v;
        for (int i = 0; i < 6; i++)
        begin
            v = 12'hFFF - 12'(i * 12'h111);
            wr(8'h00, 16'h8003 | (16'(code[i]) << 10));
            feed(v, n[i] - 1);
            aof_conv_model_inst.send(5'h04, v, 0);
            chk("early ready", 16'h0000, {15'h0000, resultReady});
            feed(v, 1);
            chk("ready", 16'h0001, {15'h0000, resultReady});
            rd(8'h04);
            chk("result", 16'(v) << f[i], rv);
        end
        $display("ratio test done");
    endtask

    task automatic t_disable();
        wr(8'h00, 16'h8003);
        feed(12'h100, 4);
        wr(8'h00, 16'h0003);
        chk("ready off", 16'h0000, {15'h0000, resultReady});
        repeat (4) aof_conv_model_inst.send(5'h03, 12'h100, 2);
        chk("ready idle", 16'h0000, {15'h0000, resultReady});
        $display("disable test done");
    endtask

    task automatic t_mode();
        wr(8'h00, 16'hE003);
        feed(12'h7A5, 4);
        rd(8'h04);
        chk("average", 16'h07A5, rv);
        wr(8'h00, 16'hA003);
        rd(8'h00);
        chk("control", 16'hA003, rv);
        feed(12'h7A5, 4);
        chk("reserved", 16'h0000, {15'h0000, resultReady});
        $display("mode test done");
    endtask

    task automatic t_irq();
        wr(8'h14, 16'h0001);
        wr(8'h00, 16'h8203);
        feed(12'h001, 4);
        chk("irq", 16'h0001, {15'h0000, irq});
        rd(8'h0C);
        chk("int status", 16'h0001, rv);
        rd(8'h08);
        chk("status", 16'h0001, rv);
        feed(12'h001, 4);
        rd(8'h0C);
        chk("overrun", 16'h0003, rv);
        wr(8'h14, 16'h0000);
        chk("irq masked", 16'h0000, {15'h0000, irq});
        wr(8'h14, 16'h0001);
        wr(8'h10, 16'h0003);
        chk("irq cleared", 16'h0000, {15'h0000, irq});
        $display("interrupt test done");
    endtask

    task automatic conclude();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Whole run needs about 1130 cycles
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 6000)
        begin
            n_mismatch++;
            conclude();
        end
    end

    initial
    begin
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        t_reset();
        t_ratio();
        t_disable();
        t_mode();
        t_irq();
        conclude();
    end
endmodule // aof_filter_test
